//--- core/acp_pkg.sv
// Constants and types for the serial command port of the converter.
// Assumes one system clock; all pins are synchronised inside the port.
//
// Function
// [R1] Hold reset after power-up until 1024 oscillator cycles have been counted.
// [R2] During start-up keep serial logic reset and the reset flag set.
// [R3] Writing one to the soft reset bit starts a reset cycle.
// [R4] Soft reset sets the flag until the bit is zeroed and configuration read.
// [R5] Reset loads configuration 000040, offset 000000 and gain 800000.
// [R6] Five registers: 8-bit command, 24-bit configuration, offset, gain, data.
// [R7] After reset the first eight bits form a command word.
// [R8] A valid read or write command is followed by 24 or 72 data clocks.
// [R9] Offset, gain and configuration read and write; conversion data is read only.
// [R10] Read command: top bit one, direction one, conversion and save bits zero.
// [R11] Write command: top bit one, direction zero, conversion and save bits zero.
// [R12] The setup group moves offset, gain, configuration: 72 data bits.
// [R13] Select field bits 3..1 choose the target; codes 101 to 111 are reserved.
// [R14] A command with a zero top bit does nothing.
// [R15] Command bit four chooses read when one and write when zero.
// [R16] Bits six, five and zero start one, continuous conversions or power save.
// [R17] The soft reset bit holds the device off until written back to zero.
// [R18] The reset flag reads one after a reset and clears when read.

package acp_pkg;

  localparam int CMD_BITS = 8;
  localparam int WORD_BITS = 24;
  localparam int GROUP_WORDS = 3;
  localparam int IMAGE_BITS = GROUP_WORDS * WORD_BITS;
  localparam int STARTUP_OSC_CYCLES = 1024;

  localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_OSC_CYCLES - 1);
  localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
  localparam logic [4:0] WORD_LAST = 5'(WORD_BITS - 1);
  localparam logic [1:0] GROUP_LAST = 2'(GROUP_WORDS - 1);

  // Command word fields.
  localparam int CB_BIT = 7;
  localparam int SC_BIT = 6;
  localparam int CC_BIT = 5;
  localparam int RW_BIT = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 1;
  localparam int PS_BIT = 0;

  localparam logic [2:0] SEL_OFFSET = 3'h0;
  localparam logic [2:0] SEL_GAIN = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_CONV = 3'h3;
  localparam logic [2:0] SEL_GROUP = 3'h4;

  // Configuration flags and reset values.
  localparam int CFG_RS_BIT = 7;
  localparam int CFG_RV_BIT = 6;
  localparam logic [23:0] CFG_RS_MASK = 24'h000080;
  localparam logic [23:0] CFG_RV_MASK = 24'h000040;
  localparam logic [23:0] CFG_RESET = 24'h000040;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET = 24'h800000;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_CMD = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ = 2'b11
  } acp_state_t;

endpackage

//--- core/acp_serial_port.sv
// Serial command port with start-up and soft reset sequencing.
// Assumes the host drives chip select, serial clock and data in, with data
// sampled on the serial clock rising edge and answered on the falling edge.

`timescale 1ns/1ps

module acp_serial_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Oscillator and serial pins
  input wire logic oscillator_clock,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  // Converter side
  input wire logic [acp_pkg::WORD_BITS-1:0] convData,
  output logic [acp_pkg::WORD_BITS-1:0] configOut,
  output logic [acp_pkg::WORD_BITS-1:0] offsetOut,
  output logic [acp_pkg::WORD_BITS-1:0] gainOut,
  output logic portReady,
  output logic one_shot_convert,
  output logic repeat_convert,
  output logic power_save_select,
  output logic reset_occurred_flag
);
  import acp_pkg::*;
  default clocking chkClk @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [2:0] sclkSync, oscSync;
  logic [1:0] csSync, sdiSync;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclkSync <= 3'h0;
      oscSync <= 3'h0;
      csSync <= 2'h3;
      sdiSync <= 2'h0;
    end else begin
      sclkSync <= {sclkSync[1:0], sclk};
      oscSync <= {oscSync[1:0], oscillator_clock};
      csSync <= {csSync[0], csN};
      sdiSync <= {sdiSync[0], sdi};
    end
  end

  // Edges are judged on the second and third stages only.
  wire sclkRise = sclkSync[1] & ~sclkSync[2];
  wire sclkFall = ~sclkSync[1] & sclkSync[2];
  wire oscRise = oscSync[1] & ~oscSync[2];
  wire csActive = ~csSync[1];
  wire sdiBit = sdiSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // State and storage.
  acp_state_t stateReg, stateNext;
  logic [10:0] oscCntReg;
  logic [4:0] bitCntReg;
  logic [1:0] wordIdxReg;
  logic [CMD_BITS-2:0] cmdShiftReg;
  logic [WORD_BITS-2:0] inShiftReg;
  logic [IMAGE_BITS:0] outShiftReg;
  logic [2:0] selReg;
  logic [WORD_BITS-1:0] cfgReg, offsetReg, gainReg, cfgOutReg;
  logic grpReg, rsHeldReg, rvFlagReg, singleReg;
  logic repeatReg, psReg, readyReg, oeReg;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  wire inStartup = (stateReg == ST_STARTUP);
  wire bitClock = csActive & sclkRise;
  wire [CMD_BITS-1:0] cmdWord = {cmdShiftReg, sdiBit};
  wire [2:0] cmdSel = cmdWord[SEL_HI:SEL_LO];
  wire cmdDone = (stateReg == ST_CMD) & bitClock
    & (bitCntReg == CMD_LAST); // [R7]
  wire cmdExec = cmdWord[CB_BIT]; // [R14]
  wire cmdCtl = cmdWord[SC_BIT] | cmdWord[CC_BIT] | cmdWord[PS_BIT];
  wire selOk = (cmdSel <= SEL_GROUP); // [R13]
  wire cmdRead = cmdWord[RW_BIT]; // [R15]
  // Conversion or save bits mark a control command with no data phase.
  wire dataCmd = cmdDone & cmdExec & ~cmdCtl & selOk; // [R10] [R11]
  // Control commands are held off until the soft reset bit is cleared.
  wire ctlCmd = cmdDone & cmdExec & cmdCtl & ~rsHeldReg; // [R16] [R17]
  wire cmdGroup = (cmdSel == SEL_GROUP);

  ////////////////////////////////////////////////////////////////////////////
  // Data phase decode.
  wire wordEnd = bitClock & (bitCntReg == WORD_LAST); // [R8]
  wire lastWord = ~grpReg | (wordIdxReg == GROUP_LAST); // [R12]
  wire wordDone = (stateReg == ST_WRITE) & wordEnd;
  wire readDone = (stateReg == ST_READ) & wordEnd & lastWord;
  wire [2:0] wrTarget = grpReg ? {1'b0, wordIdxReg} : selReg; // [R12]
  wire [WORD_BITS-1:0] wrWord = {inShiftReg, sdiBit};
  wire cfgWrite = wordDone & (wrTarget == SEL_CONFIG);
  wire softReset = cfgWrite & wrWord[CFG_RS_BIT]; // [R3]
  // The two flags live apart from the stored configuration bits.
  wire [WORD_BITS-1:0] cfgStore = wrWord & ~(CFG_RS_MASK | CFG_RV_MASK);
  wire [WORD_BITS-1:0] cfgView = cfgReg
    | (rsHeldReg ? CFG_RS_MASK : 24'h000000)
    | (rvFlagReg ? CFG_RV_MASK : 24'h000000);
  wire [WORD_BITS-1:0] selWord =
    (cmdSel == SEL_OFFSET) ? offsetReg :
    (cmdSel == SEL_GAIN) ? gainReg :
    (cmdSel == SEL_CONFIG) ? cfgView : convData; // [R9]
  wire [IMAGE_BITS-1:0] readImage = cmdGroup
    ? {offsetReg, gainReg, cfgView}
    : {selWord, {(IMAGE_BITS - WORD_BITS){1'b0}}};
  wire cfgReadHit = dataCmd & cmdRead & (cmdGroup | cmdSel == SEL_CONFIG);
  wire rvClear = cfgReadHit & ~rsHeldReg; // [R4] [R18]
  wire startupEnd = inStartup & oscRise & (oscCntReg == STARTUP_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Port sequencer.
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_STARTUP: begin
        if (startupEnd) begin
          stateNext = ST_CMD; // [R1]
        end
      end
      ST_CMD: begin
        if (dataCmd) begin
          stateNext = cmdRead ? ST_READ : ST_WRITE; // [R8] [R15]
        end
      end
      ST_WRITE: begin
        if (softReset) begin
          stateNext = ST_STARTUP; // [R3]
        end else if (!csActive || (wordDone && lastWord)) begin
          stateNext = ST_CMD;
        end
      end
      ST_READ: begin
        if (!csActive || readDone) begin
          stateNext = ST_CMD;
        end
      end
      default: begin
        stateNext = ST_STARTUP;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateReg <= ST_STARTUP;
      oscCntReg <= 11'h000;
    end else begin
      stateReg <= stateNext;
      if (!inStartup) begin
        oscCntReg <= 11'h000;
      end else if (oscRise) begin
        oscCntReg <= oscCntReg + 11'h001; // [R1]
      end
    end
  end

  // A frame drop or the start-up hold clears any partial word.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitCntReg <= 5'h00;
    end else if (inStartup || !csActive) begin
      bitCntReg <= 5'h00; // [R2]
    end else if (sclkRise) begin
      if (cmdDone || wordEnd) begin
        bitCntReg <= 5'h00;
      end else begin
        bitCntReg <= bitCntReg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmdShiftReg <= 7'h00;
      inShiftReg <= 23'h000000;
    end else if (bitClock) begin
      cmdShiftReg <= cmdWord[CMD_BITS-2:0]; // [R6]
      inShiftReg <= wrWord[WORD_BITS-2:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grpReg <= 1'b0;
      selReg <= SEL_OFFSET;
      wordIdxReg <= 2'h0;
    end else if (dataCmd) begin
      grpReg <= cmdGroup;
      selReg <= cmdSel;
      wordIdxReg <= 2'h0;
    end else if (wordEnd) begin
      wordIdxReg <= wordIdxReg + 2'h1; // [R12]
    end
  end

  // One spare leading bit: the falling edge after the command exposes MSB.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outShiftReg <= '0;
    end else if (dataCmd && cmdRead) begin
      outShiftReg <= {1'b0, readImage};
    end else if (stateReg == ST_READ && csActive && sclkFall) begin
      outShiftReg <= {outShiftReg[IMAGE_BITS-1:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup registers and reset flags.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfgReg <= CFG_RESET & ~CFG_RV_MASK;
      offsetReg <= OFFSET_RESET;
      gainReg <= GAIN_RESET;
    end else if (inStartup) begin
      cfgReg <= CFG_RESET & ~CFG_RV_MASK; // [R5]
      offsetReg <= OFFSET_RESET; // [R5]
      gainReg <= GAIN_RESET; // [R5]
    end else if (wordDone && !softReset) begin
      if (wrTarget == SEL_OFFSET) begin
        offsetReg <= wrWord; // [R9]
      end
      if (wrTarget == SEL_GAIN) begin
        gainReg <= wrWord; // [R9]
      end
      if (wrTarget == SEL_CONFIG) begin
        cfgReg <= cfgStore; // [R9]
      end
    end
  end

  // Set wins: the flag is forced on for the whole start-up period.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvFlagReg <= 1'b1;
      rsHeldReg <= 1'b0;
    end else begin
      if (inStartup) begin
        rvFlagReg <= 1'b1; // [R2] [R4]
      end else if (rvClear) begin
        rvFlagReg <= 1'b0; // [R18]
      end
      if (softReset) begin
        rsHeldReg <= 1'b1; // [R17]
      end else if (cfgWrite) begin
        rsHeldReg <= 1'b0; // [R17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion controls and pin outputs.
  // The configuration view is registered so its pins never show a glitch.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      singleReg <= 1'b0;
      repeatReg <= 1'b0;
      psReg <= 1'b0;
      readyReg <= 1'b0;
      oeReg <= 1'b0;
      cfgOutReg <= CFG_RESET;
    end else begin
      singleReg <= ctlCmd & cmdWord[SC_BIT]; // [R16]
      readyReg <= ~inStartup; // [R1]
      oeReg <= (stateReg == ST_READ) & csActive;
      cfgOutReg <= cfgView; // [R5]
      if (inStartup || rsHeldReg) begin
        repeatReg <= 1'b0;
        psReg <= 1'b0;
      end else if (ctlCmd) begin
        repeatReg <= cmdWord[CC_BIT]; // [R16]
        psReg <= cmdWord[PS_BIT]; // [R16]
      end
    end
  end

  assign sdo = outShiftReg[IMAGE_BITS];
  assign sdoOe = oeReg;
  assign configOut = cfgOutReg;
  assign offsetOut = offsetReg;
  assign gainOut = gainReg;
  assign portReady = readyReg;
  assign one_shot_convert = singleReg;
  assign repeat_convert = repeatReg;
  assign power_save_select = psReg;
  assign reset_occurred_flag = rvFlagReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence seqStartupEnd;
    stateReg == ST_STARTUP && oscRise && oscCntReg == STARTUP_LAST;
  endsequence
  sequence seqSoftReset;
    stateReg == ST_WRITE && wordDone && wrTarget == SEL_CONFIG
      && wrWord[CFG_RS_BIT];
  endsequence
  chk_startup_count: assert property ( // [R1]
    seqStartupEnd |=> stateReg == ST_CMD ##1 portReady)
    else $error("start-up did not end after the oscillator count");
  chk_startup_hold: assert property ( // [R2]
    stateReg == ST_STARTUP |=> !portReady && reset_occurred_flag
      && bitCntReg == 5'h00)
    else $error("port not held in reset during start-up");
  chk_soft_reset: assert property ( // [R3]
    seqSoftReset |=> stateReg == ST_STARTUP && rsHeldReg
      ##1 reset_occurred_flag)
    else $error("soft reset did not start a reset cycle");
  chk_reset_values: assert property ( // [R5]
    seqStartupEnd |=> offsetReg == OFFSET_RESET && gainReg == GAIN_RESET
      && configOut == (CFG_RESET | (rsHeldReg ? CFG_RS_MASK : 24'h0)))
    else $error("registers not at reset values after reset");
  chk_flag_clear: assert property ( // [R4]
    $fell(rvFlagReg) |-> $past(cfgReadHit) && !$past(rsHeldReg))
    else $error("reset flag cleared without a qualifying read");
  chk_null_cmd: assert property ( // [R14]
    cmdDone && !cmdWord[CB_BIT] |=> stateReg == ST_CMD
      && !one_shot_convert)
    else $error("null command caused an operation");
  chk_cmd_dir: assert property ( // [R15]
    dataCmd |=> stateReg == ($past(cmdRead) ? ST_READ : ST_WRITE))
    else $error("data phase direction wrong");
  chk_conv_readonly: assert property ( // [R9]
    wordDone && wrTarget == SEL_CONV |=> $stable(offsetReg)
      && $stable(gainReg) && $stable(cfgReg))
    else $error("write to conversion data changed a register");
  chk_single_pulse: assert property ( // [R16]
    one_shot_convert |=> !one_shot_convert)
    else $error("single conversion start longer than one cycle");
  chk_reserved_sel: assert property ( // [R13]
    cmdDone && cmdSel > SEL_GROUP |=> stateReg == ST_CMD)
    else $error("reserved select code entered data mode");
endmodule

//--- tb/acp_host_model.sv
// Host side of the four-wire serial port: frames commands and data.
// Assumes clk_sys paces it; pins change only at clk_sys falling edges.

`timescale 1ns/1ps

module acp_host_model (
  // Pacing clock
  input wire logic clk_sys,
  // Serial pins
  output logic csN,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOe
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Half of the 400 ns serial clock period.
  task automatic half_wait;
    repeat (4) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One chip-select frame: command MSB first, then nData data bits.
  // A bit is sampled just before the rising edge, when the device must have
  // answered the preceding fall; an undriven pin reads as unknown.
  task automatic frame(input logic [7:0] cmd, input int nData,
                       input logic [71:0] wr, output logic [71:0] rd);
    int i;
    rd = '0;
    @(negedge clk_sys);
    csN = 1'b0;
    half_wait();
    for (i = 0; i < 8 + nData; i++) begin
      sdi = (i < 8) ? cmd[7-i] : wr[nData-1-(i-8)];
      half_wait();
      if (i >= 8) begin
        rd = {rd[70:0], sdoOe ? sdo : 1'bx};
      end
      sclk = 1'b1;
      half_wait();
      sclk = 1'b0;
    end
    half_wait();
    csN = 1'b1;
    sdi = ~sdi;
    half_wait();
  endtask
endmodule

//--- tb/tb_adc_serial_command_port.sv
// Self-checking bench for the serial command port.
// Assumes a 20 MHz system clock and a free-running 2 MHz oscillator input.

`timescale 1ns/1ps

module tb_adc_serial_command_port;
  import acp_pkg::*;

  logic clkSys, rst, oscClk, csN, sclk, sdi, sdo, sdoOe;
  logic [23:0] convData, configOut, offsetOut, gainOut;
  logic portReady, oneShot, repeatConv, powerSave, resetFlag;
  logic [23:0] shadow [3];
  logic [71:0] rd;
  int numErrors = 0;
  int checkCount = 0;
  int shotCount = 0;

  acp_serial_port dut (
    .clk_sys(clkSys), .rst(rst), .oscillator_clock(oscClk), .csN(csN),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .convData(convData),
    .configOut(configOut), .offsetOut(offsetOut), .gainOut(gainOut),
    .portReady(portReady), .one_shot_convert(oneShot),
    .repeat_convert(repeatConv), .power_save_select(powerSave),
    .reset_occurred_flag(resetFlag)
  );

  acp_host_model host (
    .clk_sys(clkSys), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdoOe(sdoOe)
  );

  initial clkSys = 1'b0;
  always #25 clkSys = ~clkSys;

  // Offset from the system clock so oscillator edges never meet its edges.
  initial begin
    oscClk = 1'b0;
    #10;
    forever #250 oscClk = ~oscClk;
  end

  always @(posedge clkSys) begin
    if (!rst && oneShot === 1'b1) shotCount++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Errors %0d, checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] cmd_word(input logic rw,
                                          input logic [2:0] sel);
    return {1'b1, 2'b00, rw, sel, 1'b0};
  endfunction

  // Flag bits of the configuration are not stored as written.
  function automatic logic [23:0] stored(input logic [2:0] sel,
                                         input logic [23:0] w);
    return (sel == SEL_CONFIG) ? (w & ~(CFG_RS_MASK | CFG_RV_MASK)) : w;
  endfunction

  task automatic xfer(input logic [7:0] cmd, input int n,
                      input logic [71:0] wr);
    host.frame(cmd, n, wr, rd);
    repeat (8) @(negedge clkSys);
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    while (portReady !== 1'b1 && k < 12000) begin
      @(negedge clkSys);
      k++;
    end
    check(72'(portReady), 72'(1));
  endtask

  task automatic check_regs;
    check({offsetOut, gainOut, configOut},
          {shadow[0], shadow[1], shadow[2]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [2:0] sel;
    logic [23:0] w;
    logic [71:0] g;
    rst = 1'b1;
    convData = '0;
    void'($urandom(53));
    repeat (6) @(negedge clkSys);
    rst = 1'b0;
    repeat (4) @(negedge clkSys);
    check(72'(portReady), 72'(0));
    check(72'(resetFlag), 72'(1));
    check({offsetOut, gainOut, configOut},
          {OFFSET_RESET, GAIN_RESET, CFG_RESET});
    wait_ready();
    xfer(cmd_word(1'b1, SEL_GROUP), IMAGE_BITS, '0);
    check(rd, {OFFSET_RESET, GAIN_RESET, CFG_RESET});
    check(72'(resetFlag), 72'(0));
    shadow = '{OFFSET_RESET, GAIN_RESET, CFG_RESET & ~CFG_RV_MASK};
    // Random single-register writes, each read back; first is all ones.
    for (i = 0; i < 8; i++) begin
      sel = (i == 0) ? SEL_OFFSET : 3'($urandom_range(0, 2));
      w = (i == 0) ? 24'hFFFFFF : 24'($urandom);
      // A set soft reset bit here would restart the port mid-sequence.
      if (sel == SEL_CONFIG) w[CFG_RS_BIT] = 1'b0;
      xfer(cmd_word(1'b0, sel), WORD_BITS, 72'(w));
      shadow[sel] = stored(sel, w);
      check_regs();
      xfer(cmd_word(1'b1, sel), WORD_BITS, '0);
      check(72'(rd[23:0]), 72'(shadow[sel]));
    end
    g = {24'($urandom), 24'($urandom), stored(SEL_CONFIG, 24'($urandom))};
    xfer(cmd_word(1'b0, SEL_GROUP), IMAGE_BITS, g);
    check({offsetOut, gainOut, configOut}, g);
    shadow = '{g[71:48], g[47:24], g[23:0]};
    w = 24'($urandom);
    convData = w;
    xfer(cmd_word(1'b1, SEL_CONV), WORD_BITS, '0);
    check(72'(rd[23:0]), 72'(w));
    xfer(cmd_word(1'b0, SEL_CONV), WORD_BITS, 72'(~w));
    check_regs();
    // Null and reserved commands leave everything alone.
    for (i = 0; i < 4; i++) begin
      xfer((i == 0) ? 8'h00 : cmd_word(i[0], 3'(4 + i)), 0, '0);
      check_regs();
      check(72'(sdoOe), 72'(0));
    end
    xfer(cmd_word(1'b1, SEL_OFFSET), WORD_BITS, '0);
    check(72'(rd[23:0]), 72'(shadow[0]));
    xfer(8'hC0, 0, '0);
    check(72'(shotCount), 72'(1));
    xfer(8'hA0, 0, '0);
    check(72'({repeatConv, powerSave}), 72'(2'b10));
    xfer(8'h81, 0, '0);
    check(72'({repeatConv, powerSave}), 72'(2'b01));
    // Soft reset, held until the bit is written back to zero.
    xfer(cmd_word(1'b0, SEL_CONFIG), WORD_BITS, 72'(CFG_RS_MASK));
    check(72'(portReady), 72'(0));
    check({offsetOut, gainOut, configOut},
          {OFFSET_RESET, GAIN_RESET, CFG_RESET | CFG_RS_MASK});
    check(72'({resetFlag, repeatConv, powerSave}), 72'(3'b100));
    wait_ready();
    xfer(8'hA0, 0, '0);
    check(72'(repeatConv), 72'(0));
    xfer(cmd_word(1'b1, SEL_CONFIG), WORD_BITS, '0);
    check(72'(rd[23:0]), 72'(CFG_RESET | CFG_RS_MASK));
    check(72'(resetFlag), 72'(1));
    xfer(cmd_word(1'b0, SEL_CONFIG), WORD_BITS, '0);
    check(72'(configOut), 72'(CFG_RESET));
    xfer(cmd_word(1'b1, SEL_CONFIG), WORD_BITS, '0);
    check(72'(rd[23:0]), 72'(CFG_RESET));
    check(72'({configOut, resetFlag}), 72'(0));
    end_sim();
  end

  // Two start-ups and the frames need well under this many cycles.
  initial begin
    repeat (90000) @(posedge clkSys);
    numErrors++;
    $display("Watchdog expired at t=%0t", $time);
    end_sim();
  end
endmodule
